// ===== hw/lock_fault_cfg.svh
// Register offsets, field positions, reset values and timing constants
// for the lock fault response controller.
// Assumes a 10 MHz core clock and a 32-bit classic Wishbone register bus.
`ifndef LOCK_FAULT_CFG_SVH
`define LOCK_FAULT_CFG_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define OFS_LOCK_FAULT_CONFIG 8'h00
`define OFS_LOCK_CTRL 8'h04
`define OFS_LOCK_IRQ_STATUS 8'h08
`define OFS_LOCK_IRQ_MASK 8'h0C
`define OFS_LOCK_STATE 8'h10

// ****************************************
// Configuration fields
// ****************************************
`define CUR_ACT_MSB 18
`define CUR_ACT_LSB 15
`define FILT_MSB 14
`define FILT_LSB 11
`define RETRY_MSB 10
`define RETRY_LSB 7
`define STALL_MSB 6
`define STALL_LSB 3

// Control register: retry limit and latched fault clear strobes
`define LIMIT_MSB 2
`define LIMIT_LSB 0
`define CLR_CUR_BIT 8
`define CLR_STALL_BIT 9

// Status and mask layout
`define IRQ_CUR_FAULT 0
`define IRQ_STALL_FAULT 1
`define IRQ_CUR_LATCH 2
`define IRQ_STALL_LATCH 3
`define IRQ_W 4

// ****************************************
// Reset values
// ****************************************
`define RST_LOCK_FAULT_CONFIG 32'h0000_0000
`define RST_RETRY_LIMIT 3'h3
`define RST_IRQ_MASK 4'h0

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ 10
`define TICK_US 50
`define TICK_CYC (`CLK_MHZ * `TICK_US)
`define TIME_W 20

`endif

// ===== hw/lock_fault_chan.sv
// One lock detection channel: deglitch, action decode, retry timing
// and latching.
// Assumes a one-cycle tick pulse from the parent and a synchronous detect.
`timescale 1ns/10ps
`default_nettype none

`include "lock_fault_cfg.svh"

module lock_fault_chan (
	input wire logic clk, // Core clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic tick, // One-cycle time base pulse
	input wire logic det, // Raw lock detect level
	input wire logic filt_en, // Deglitch filter in use
	input wire logic [3:0] action, // Action code
	input wire logic [`TIME_W-1:0] filt_ticks, // Deglitch length in ticks
	input wire logic [`TIME_W-1:0] retry_ticks, // Retry interval in ticks
	input wire logic [2:0] retry_limit, // Allowed automatic retries
	input wire logic clr_latched, // Clear a latched fault
	output logic fault, // Fault pin contribution
	output lock_fault_pkg::drv_mode_t drv_mode, // Driver action
	output logic fault_evt, // Pulse on fault entry
	output logic latch_evt, // Pulse on latch entry
	output lock_fault_pkg::chan_state_t state, // Current state
	output logic [2:0] retry_cnt // Retries used
);

	lock_fault_pkg::chan_state_t state_q, state_d;
	lock_fault_pkg::drv_mode_t mode_q;
	logic [`TIME_W-1:0] filt_cnt_q;
	logic [`TIME_W-1:0] timer_q;
	logic [2:0] retry_cnt_q;
	logic qual;
	logic disabled;
	logic auto_code;
	logic go_latch;

	// ****************************************
	// Deglitch
	// ****************************************
	assign qual = filt_en ? (det && filt_cnt_q >= filt_ticks) : det;
	assign disabled = action > 4'h8;
	assign auto_code = action[2];
	assign go_latch = !auto_code || retry_cnt_q >= retry_limit;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			filt_cnt_q <= '0;
		else if (!det || disabled)
			filt_cnt_q <= '0;
		else if (tick && filt_cnt_q < filt_ticks)
			filt_cnt_q <= filt_cnt_q + 1'b1;
	end

	// ****************************************
	// State machine
	// ****************************************
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			lock_fault_pkg::CH_IDLE:
			begin
				if (qual && !disabled)
				begin
					if (action == 4'h8)
						state_d = lock_fault_pkg::CH_REPORT;
					else if (go_latch)
						state_d = lock_fault_pkg::CH_LATCHED;
					else
						state_d = lock_fault_pkg::CH_RETRY;
				end
			end
			lock_fault_pkg::CH_RETRY:
			begin
				if (tick && timer_q >= retry_ticks)
					state_d = lock_fault_pkg::CH_IDLE;
			end
			lock_fault_pkg::CH_LATCHED:
			begin
				if (clr_latched)
					state_d = lock_fault_pkg::CH_IDLE;
			end
			lock_fault_pkg::CH_REPORT:
			begin
				if (!qual || disabled)
					state_d = lock_fault_pkg::CH_IDLE;
			end
			default: state_d = lock_fault_pkg::CH_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state_q <= lock_fault_pkg::CH_IDLE;
		else
			state_q <= state_d;
	end

	// Driver action held from fault entry, so a later code change cannot alter it
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			mode_q <= lock_fault_pkg::DRV_NORMAL;
		else if (state_q == lock_fault_pkg::CH_IDLE && state_d != lock_fault_pkg::CH_IDLE)
		begin
			case (action)
				4'h0, 4'h4: mode_q <= lock_fault_pkg::DRV_TRISTATE;
				4'h1, 4'h5: mode_q <= lock_fault_pkg::DRV_RECIRC;
				4'h2, 4'h6: mode_q <= lock_fault_pkg::DRV_HS_BRAKE;
				4'h3, 4'h7: mode_q <= lock_fault_pkg::DRV_LS_BRAKE;
				default: mode_q <= lock_fault_pkg::DRV_NORMAL;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			timer_q <= '0;
		else if (state_q != lock_fault_pkg::CH_RETRY)
			timer_q <= '0;
		else if (tick)
			timer_q <= timer_q + 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			retry_cnt_q <= '0;
		else if (state_q == lock_fault_pkg::CH_LATCHED && clr_latched)
			retry_cnt_q <= '0;
		else if (state_q == lock_fault_pkg::CH_IDLE && state_d == lock_fault_pkg::CH_RETRY)
			retry_cnt_q <= retry_cnt_q + 1'b1;
	end

	assign fault = state_q != lock_fault_pkg::CH_IDLE;
	assign drv_mode = fault ? mode_q : lock_fault_pkg::DRV_NORMAL;
	assign fault_evt = state_q == lock_fault_pkg::CH_IDLE && state_d != lock_fault_pkg::CH_IDLE;
	assign latch_evt = state_q != lock_fault_pkg::CH_LATCHED
		&& state_d == lock_fault_pkg::CH_LATCHED;
	assign state = state_q;
	assign retry_cnt = retry_cnt_q;

endmodule

`default_nettype wire

// ===== hw/lock_fault_pkg.sv
// Types shared by the lock fault response controller and its channels.
// Assumes nothing of its surroundings.
package lock_fault_pkg;

	// Gate driver action requested by a lock channel
	typedef enum logic [2:0] {
		DRV_NORMAL = 3'h0,
		DRV_TRISTATE = 3'h1,
		DRV_RECIRC = 3'h2,
		DRV_HS_BRAKE = 3'h3,
		DRV_LS_BRAKE = 3'h4
	} drv_mode_t;

	// Channel states, Gray coded along idle, retry, latched
	typedef enum logic [1:0] {
		CH_IDLE = 2'h0,
		CH_RETRY = 2'h1,
		CH_LATCHED = 2'h3,
		CH_REPORT = 2'h2
	} chan_state_t;

endpackage

// ===== hw/lock_fault_response_ctrl.sv
// Lock fault response controller: Wishbone registers, time base and the
// two lock channels, combined onto the driver action and the fault pin.
// Assumes synchronous detect inputs and a classic Wishbone master.
//
// Functional notes
// - Current-lock codes 0-3 latch with driver action
// - Codes 4,5,7 auto-clear, latch past retry limit
// - Code 6 auto-clears, high-side brake during fault
// - Code 8 reports on fault pin only
// - Codes 9-F disable current-lock detection
// - Current-lock deglitch selected from sixteen times
// - Retry interval 100 ms, 500 ms, 1-14 s
// - Motor-lock codes 0-3 latch with driver action
// - Motor-lock codes 4-7 auto-clear within retry limit
// - Motor-lock code 8 reports, 9-F disable
//
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none

`include "lock_fault_cfg.svh"

module lock_fault_response_ctrl #(
	parameter int CYCLES_PER_TICK = `TICK_CYC // Clock cycles per 50 us tick
) (
	input wire logic CORE_CLK, // Core clock, 10 MHz
	input wire logic RESETN, // Asynchronous reset, active low
	input wire logic WB_CYC_I, // Bus cycle
	input wire logic WB_STB_I, // Strobe
	input wire logic WB_WE_I, // Write enable
	input wire logic [7:0] WB_ADR_I, // Byte address
	input wire logic [3:0] WB_SEL_I, // Byte enables
	input wire logic [31:0] WB_DAT_I, // Write data
	output logic [31:0] WB_DAT_O, // Read data
	output logic WB_ACK_O, // Acknowledge
	input wire logic CURRENT_LOCK_DET, // Current threshold lock detect
	input wire logic STALL_DET, // Motor lock detect
	output logic [2:0] DRV_MODE, // Gate driver action
	output logic FAULT_OUT_N, // Fault pin, active low
	output logic IRQ // Interrupt, active high level
);

	// ****************************************
	// Declarations
	// ****************************************
	logic [31:0] lock_fault_config_q;
	logic [2:0] retry_limit_count_q;
	logic [`IRQ_W-1:0] irq_status_q;
	logic [`IRQ_W-1:0] irq_mask_q;
	logic [`IRQ_W-1:0] irq_set;
	logic ack_q;
	logic [31:0] dat_q;
	logic [2:0] drv_q;
	logic fault_n_q;
	logic bus_req;
	logic wr_en;
	logic rd_en;
	logic clr_cur;
	logic clr_stall;
	logic [31:0] tick_cnt_q;
	logic tick;
	logic [3:0] cur_action;
	logic [3:0] current_lock_filter_time;
	logic [3:0] lock_retry_interval;
	logic [3:0] stall_action_sel;
	logic [`TIME_W-1:0] filt_ticks;
	logic [`TIME_W-1:0] retry_ticks;
	logic cur_fault;
	logic stall_fault;
	logic cur_fevt;
	logic stall_fevt;
	logic cur_levt;
	logic stall_levt;
	lock_fault_pkg::drv_mode_t cur_drv;
	lock_fault_pkg::drv_mode_t stall_drv;
	lock_fault_pkg::chan_state_t cur_state;
	lock_fault_pkg::chan_state_t stall_state;
	logic [2:0] cur_retries;
	logic [2:0] stall_retries;

	// ****************************************
	// Functions
	// ****************************************

	// Byte-lane merge of a write into a 32-bit register
	function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
				r[i*8 +: 8] = wd[i*8 +: 8];
		end
		return r;
	endfunction

	// Deglitch time in microseconds, converted to ticks
	function automatic logic [`TIME_W-1:0] filt_lookup(input logic [3:0] code);
		int us;
		us = 50;
		case (code)
			4'h0: us = 50;
			4'h1: us = 100;
			4'h2: us = 200;
			4'h3: us = 500;
			4'h4: us = 1000;
			4'h5: us = 2500;
			4'h6: us = 5000;
			4'h7: us = 7500;
			4'h8: us = 10000;
			4'h9: us = 25000;
			4'hA: us = 50000;
			4'hB: us = 75000;
			4'hC: us = 100000;
			4'hD: us = 200000;
			4'hE: us = 500000;
			4'hF: us = 1000000;
			default: us = 50;
		endcase
		return `TIME_W'(us / `TICK_US);
	endfunction

	// Retry interval in milliseconds, converted to ticks
	function automatic logic [`TIME_W-1:0] retry_lookup(input logic [3:0] code);
		int ms;
		ms = 100;
		case (code)
			4'h0: ms = 100;
			4'h1: ms = 500;
			default: ms = (int'(code) - 1) * 1000;
		endcase
		return `TIME_W'((ms * 1000) / `TICK_US);
	endfunction

	// ****************************************
	// Configuration fields
	// ****************************************
	assign cur_action = lock_fault_config_q[`CUR_ACT_MSB:`CUR_ACT_LSB];
	assign current_lock_filter_time = lock_fault_config_q[`FILT_MSB:`FILT_LSB];
	assign lock_retry_interval = lock_fault_config_q[`RETRY_MSB:`RETRY_LSB];
	assign stall_action_sel = lock_fault_config_q[`STALL_MSB:`STALL_LSB];
	assign filt_ticks = filt_lookup(current_lock_filter_time);
	assign retry_ticks = retry_lookup(lock_retry_interval);

	// ****************************************
	// Time base
	// ****************************************
	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
			tick_cnt_q <= 32'h0000_0000;
		else if (tick)
			tick_cnt_q <= 32'h0000_0000;
		else
			tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
	end

	assign tick = tick_cnt_q >= 32'(CYCLES_PER_TICK - 1);

	// ****************************************
	// Wishbone slave
	// ****************************************
	assign bus_req = WB_CYC_I && WB_STB_I && !ack_q;
	assign wr_en = bus_req && WB_WE_I;
	assign rd_en = bus_req && !WB_WE_I;
	assign clr_cur = wr_en && WB_ADR_I == `OFS_LOCK_CTRL && WB_SEL_I[1]
		&& WB_DAT_I[`CLR_CUR_BIT];
	assign clr_stall = wr_en && WB_ADR_I == `OFS_LOCK_CTRL && WB_SEL_I[1]
		&& WB_DAT_I[`CLR_STALL_BIT];

	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
			ack_q <= 1'b0;
		else
			ack_q <= bus_req;
	end

	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
			lock_fault_config_q <= `RST_LOCK_FAULT_CONFIG;
		else if (wr_en && WB_ADR_I == `OFS_LOCK_FAULT_CONFIG)
			lock_fault_config_q <= merge_sel(lock_fault_config_q, WB_DAT_I, WB_SEL_I);
	end

	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
			retry_limit_count_q <= `RST_RETRY_LIMIT;
		else if (wr_en && WB_ADR_I == `OFS_LOCK_CTRL && WB_SEL_I[0])
			retry_limit_count_q <= WB_DAT_I[`LIMIT_MSB:`LIMIT_LSB];
	end

	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
			irq_mask_q <= `RST_IRQ_MASK;
		else if (wr_en && WB_ADR_I == `OFS_LOCK_IRQ_MASK && WB_SEL_I[0])
			irq_mask_q <= WB_DAT_I[`IRQ_W-1:0];
	end

	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
			dat_q <= 32'h0000_0000;
		else if (rd_en)
		begin
			case (WB_ADR_I)
				`OFS_LOCK_FAULT_CONFIG: dat_q <= lock_fault_config_q;
				`OFS_LOCK_CTRL: dat_q <= {29'h0000_0000, retry_limit_count_q};
				`OFS_LOCK_IRQ_STATUS: dat_q <= {28'h000_0000, irq_status_q};
				`OFS_LOCK_IRQ_MASK: dat_q <= {28'h000_0000, irq_mask_q};
				`OFS_LOCK_STATE: dat_q <= {18'h0_0000, ~fault_n_q, drv_q,
					stall_retries, cur_retries, stall_state, cur_state};
				default: dat_q <= 32'h0000_0000;
			endcase
		end
	end

	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = dat_q;

	// ****************************************
	// Lock channels
	// ****************************************
	lock_fault_chan u_cur (
		.clk(CORE_CLK),
		.rst_n(RESETN),
		.tick(tick),
		.det(CURRENT_LOCK_DET),
		.filt_en(1'b1),
		.action(cur_action),
		.filt_ticks(filt_ticks),
		.retry_ticks(retry_ticks),
		.retry_limit(retry_limit_count_q),
		.clr_latched(clr_cur),
		.fault(cur_fault),
		.drv_mode(cur_drv),
		.fault_evt(cur_fevt),
		.latch_evt(cur_levt),
		.state(cur_state),
		.retry_cnt(cur_retries)
	);

	lock_fault_chan u_stall (
		.clk(CORE_CLK),
		.rst_n(RESETN),
		.tick(tick),
		.det(STALL_DET),
		.filt_en(1'b0),
		.action(stall_action_sel),
		.filt_ticks(filt_ticks),
		.retry_ticks(retry_ticks),
		.retry_limit(retry_limit_count_q),
		.clr_latched(clr_stall),
		.fault(stall_fault),
		.drv_mode(stall_drv),
		.fault_evt(stall_fevt),
		.latch_evt(stall_levt),
		.state(stall_state),
		.retry_cnt(stall_retries)
	);

	// ****************************************
	// Outputs to the power stage
	// ****************************************

	// Current-lock action takes the stage first when both channels act
	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
			drv_q <= 3'h0;
		else if (cur_drv != lock_fault_pkg::DRV_NORMAL)
			drv_q <= cur_drv;
		else
			drv_q <= stall_drv;
	end

	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
			fault_n_q <= 1'b1;
		else
			fault_n_q <= !(cur_fault || stall_fault);
	end

	assign DRV_MODE = drv_q;
	assign FAULT_OUT_N = fault_n_q;

	// ****************************************
	// Interrupts
	// ****************************************
	assign irq_set = {stall_levt, cur_levt, stall_fevt, cur_fevt};

	// A new event wins over a write-one clear in the same cycle
	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
			irq_status_q <= '0;
		else if (wr_en && WB_ADR_I == `OFS_LOCK_IRQ_STATUS && WB_SEL_I[0])
			irq_status_q <= (irq_status_q & ~WB_DAT_I[`IRQ_W-1:0]) | irq_set;
		else
			irq_status_q <= irq_status_q | irq_set;
	end

	assign IRQ = |(irq_status_q & irq_mask_q);

endmodule

`default_nettype wire

// ===== tb/lock_fault_checker.sv
// Port checker for the lock fault response controller.
// Bound into the top module; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module lock_fault_checker #(
	parameter int CYCLES_PER_TICK = 500 // Clock cycles per tick
) (
	input wire logic CORE_CLK, // Core clock
	input wire logic RESETN, // Reset, active low
	input wire logic WB_CYC_I, // Bus cycle
	input wire logic WB_STB_I, // Strobe
	input wire logic WB_WE_I, // Write enable
	input wire logic [7:0] WB_ADR_I, // Address
	input wire logic [3:0] WB_SEL_I, // Byte enables
	input wire logic [31:0] WB_DAT_I, // Write data
	input wire logic [31:0] WB_DAT_O, // Read data
	input wire logic WB_ACK_O, // Acknowledge
	input wire logic CURRENT_LOCK_DET, // Current lock detect
	input wire logic STALL_DET, // Motor lock detect
	input wire logic [2:0] DRV_MODE, // Driver action
	input wire logic FAULT_OUT_N, // Fault pin
	input wire logic IRQ // Interrupt
);
// ****
// Shadow of the configuration and a count of cycles with both types off
// ****
logic [31:0] cfg_q;
logic [2:0] dis_q;
logic take;
assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
always_ff @(posedge CORE_CLK or negedge RESETN)
begin
	if (!RESETN)
		cfg_q <= 32'h0000_0000;
	else if (take && WB_WE_I && WB_ADR_I == 8'h00 && WB_SEL_I == 4'hF)
		cfg_q <= WB_DAT_I;
end
always_ff @(posedge CORE_CLK or negedge RESETN)
begin
	if (!RESETN)
		dis_q <= 3'h0;
	else if (cfg_q[18:15] < 4'h9 || cfg_q[6:3] < 4'h9)
		dis_q <= 3'h0;
	else if (dis_q != 3'h7)
		dis_q <= dis_q + 3'h1;
end
// ****
// Properties
// ****
default clocking cb @(posedge CORE_CLK);
endclocking
default disable iff (!RESETN);
a_ack_follows: assert property (take |=> WB_ACK_O)
	else $error("ack missing after request");
a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
	else $error("ack longer than one cycle");
a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(take))
	else $error("ack without request");
a_unmapped_zero: assert property (take && !WB_WE_I && WB_ADR_I > 8'h10
	|=> WB_DAT_O == 32'h0000_0000)
	else $error("unmapped read not zero");
a_drv_fault: assert property (DRV_MODE != 3'h0 |-> !FAULT_OUT_N)
	else $error("driver action without fault pin");
a_stall_fault: assert property (STALL_DET && cfg_q[6:3] <= 4'h8 |-> ##[0:3] !FAULT_OUT_N)
	else $error("motor lock not reported");
a_dis_quiet: assert property (dis_q >= 3'h5 && FAULT_OUT_N |=> FAULT_OUT_N)
	else $error("fault raised while detection off");
a_release_norm: assert property ($rose(FAULT_OUT_N) |-> DRV_MODE == 3'h0)
	else $error("drivers not normal after release");
c_hs_brake: cover property (!FAULT_OUT_N && DRV_MODE == 3'h3);
c_report: cover property (!FAULT_OUT_N && DRV_MODE == 3'h0);
c_release: cover property ($rose(FAULT_OUT_N));
endmodule
bind lock_fault_response_ctrl lock_fault_checker #(.CYCLES_PER_TICK(CYCLES_PER_TICK)) chk_u (
	.CORE_CLK(CORE_CLK), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
	.WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .CURRENT_LOCK_DET(CURRENT_LOCK_DET),
	.STALL_DET(STALL_DET), .DRV_MODE(DRV_MODE), .FAULT_OUT_N(FAULT_OUT_N), .IRQ(IRQ));
`default_nettype wire

// ===== tb/lock_fault_response_ctrl_test.sv
// Self-checking bench for the lock fault response controller.
// Assumes the checker and power stage model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module lock_fault_response_ctrl_test;
// ****
// Stimulus, model and tasks
// ****
logic clk = 1'b0;
logic rst_n = 1'b0;
logic cyc = 1'b0;
logic stb = 1'b0;
logic we = 1'b0;
logic [7:0] adr = 8'h00;
logic [3:0] sel = 4'h0;
logic [31:0] dat = 32'h0000_0000;
logic cur_req = 1'b0;
logic stall_req = 1'b0;
logic [31:0] rdat;
logic ack;
logic cur_det;
logic stall_det;
logic [2:0] drv;
logic fault_n;
logic irq;
logic [31:0] rd;
logic [31:0] rnd;
int fails = 0;
int num_checks = 0;
int cycles = 0;
int n;
int used = 0;
int rt[$] = '{2000, 10000};
int ft[$] = '{1, 2, 4, 10};
always #50 clk = ~clk;
lock_fault_response_ctrl #(.CYCLES_PER_TICK(1)) dut_u (.CORE_CLK(clk), .RESETN(rst_n),
	.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
	.WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .CURRENT_LOCK_DET(cur_det),
	.STALL_DET(stall_det), .DRV_MODE(drv), .FAULT_OUT_N(fault_n), .IRQ(irq));
power_stage_model stage_u (.clk(clk), .rst_n(rst_n), .cur_req(cur_req),
	.stall_req(stall_req), .drv_mode(drv), .fault_n(fault_n), .cur_det(cur_det),
	.stall_det(stall_det), .braking());
task automatic close_out();
	$display("checks %0d mismatches %0d", num_checks, fails);
	if (fails == 0 && num_checks > 0)
		$display("All checks passed");
	else
		$display("Checks failed");
	$finish;
endtask
always @(posedge clk)
begin
	cycles++;
	if (cycles == 40000)
	begin
		fails++;
		close_out();
	end
end
task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
	num_checks++;
	if (seen !== exp)
	begin
		fails++;
		$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
	end
endtask
task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
	@(posedge clk);
	cyc <= 1'b1;
	stb <= 1'b1;
	we <= w;
	adr <= a;
	sel <= 4'hF;
	dat <= d;
	// Ack and read data are sampled at the rising edge; only the bench timeout ends a wait
	do
	begin
		@(posedge clk);
	end
	while (ack !== 1'b1);
	rd = rdat;
	cyc <= 1'b0;
	stb <= 1'b0;
	we <= 1'b0;
endtask
task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
	wb(1'b0, a, 32'h0000_0000);
	chk(rd, exp);
endtask
task automatic set_cfg(input logic [3:0] c, input logic [3:0] f, input logic [3:0] s);
	wb(1'b1, 8'h00, {13'h0000, c, f, 4'h0, s, 3'h0});
endtask
task automatic lock(input logic ch, input logic v);
	@(posedge clk);
	if (ch)
		cur_req <= v;
	else
		stall_req <= v;
endtask
task automatic wait_fault(input logic lvl, input int lim);
	n = 0;
	while (fault_n !== lvl && n < lim)
	begin
		@(negedge clk);
		n++;
	end
endtask
task automatic outs(input logic [2:0] d, input logic f);
	@(negedge clk);
	chk({29'h0, drv}, {29'h0, d});
	chk({31'h0, fault_n}, {31'h0, f});
endtask
task automatic irq_is(input logic v);
	@(negedge clk);
	chk({31'h0, irq}, {31'h0, v});
endtask
function automatic logic [2:0] exp_drv(input int c);
	return (c < 8) ? 3'(c % 4 + 1) : 3'h0;
endfunction
// ****
// Test sequence
// ****
initial
begin
	rd = $urandom(37);
	repeat (8) @(posedge clk);
	rst_n <= 1'b1;
	outs(3'h0, 1'b1);
	rchk(8'h00, 32'h0000_0000);
	rchk(8'h04, 32'h0000_0003);
	rchk(8'h08, 32'h0000_0000);
	rchk(8'h0C, 32'h0000_0000);
	rnd = $urandom;
	wb(1'b1, 8'h00, rnd);
	rchk(8'h00, rnd);
	wb(1'b1, 8'h14, 32'hFFFF_FFFF);
	rchk(8'h14, 32'h0000_0000);
	$display("test registers done");
	wb(1'b1, 8'h04, 32'h0000_0000);
	for (int ch = 0; ch < 2; ch++)
	begin
		for (int c = 0; c < 16; c++)
		begin
			set_cfg(ch ? 4'(c) : 4'h9, 4'h0, ch ? 4'h9 : 4'(c));
			lock(ch == 1, 1'b1);
			repeat (6) @(posedge clk);
			outs(exp_drv(c), c > 8);
			lock(ch == 1, 1'b0);
			wb(1'b1, 8'h04, ch ? 32'h0000_0100 : 32'h0000_0200);
			repeat (3) @(posedge clk);
			outs(3'h0, 1'b1);
		end
	end
	$display("test action codes done");
	wb(1'b1, 8'h08, 32'h0000_000F);
	set_cfg(4'h9, 4'h0, 4'h0);
	lock(1'b0, 1'b1);
	repeat (4) @(posedge clk);
	rchk(8'h08, 32'h0000_000A);
	irq_is(1'b0);
	wb(1'b1, 8'h0C, 32'h0000_0002);
	irq_is(1'b1);
	wb(1'b1, 8'h08, 32'h0000_0002);
	rchk(8'h08, 32'h0000_0008);
	irq_is(1'b0);
	lock(1'b0, 1'b0);
	wb(1'b1, 8'h04, 32'h0000_0200);
	wb(1'b1, 8'h0C, 32'h0000_0000);
	$display("test interrupt done");
	set_cfg(4'h0, 4'h3, 4'h9);
	lock(1'b1, 1'b1);
	repeat (6) @(posedge clk);
	lock(1'b1, 1'b0);
	repeat (4) @(posedge clk);
	outs(3'h0, 1'b1);
	lock(1'b1, 1'b1);
	wait_fault(1'b0, 30);
	chk({31'h0, n >= ft[3] && n <= ft[3] + 5}, 32'h1);
	lock(1'b1, 1'b0);
	wb(1'b1, 8'h04, 32'h0000_0100);
	$display("test deglitch done");
	wb(1'b1, 8'h04, 32'h0000_0002);
	set_cfg(4'h6, 4'h0, 4'h9);
	lock(1'b1, 1'b1);
	for (int k = 0; k < 3; k++)
	begin
		wait_fault(1'b0, 20);
		outs(3'h3, 1'b0);
		wait_fault(1'b1, 2100);
		if (used < 2)
			chk({31'h0, n > rt[0] - 5 && n < rt[0] + 4}, 32'h1);
		else
			chk({31'h0, fault_n}, 32'h0);
		used++;
	end
	// Latched, two retries used, high-side brake, fault active
	rchk(8'h10, 32'h0000_2C23);
	lock(1'b1, 1'b0);
	wb(1'b1, 8'h04, 32'h0000_0102);
	repeat (2) @(posedge clk);
	outs(3'h0, 1'b1);
	lock(1'b1, 1'b1);
	wait_fault(1'b0, 20);
	wait_fault(1'b1, 2100);
	chk({31'h0, fault_n}, 32'h1);
	lock(1'b1, 1'b0);
	$display("test retry done");
	close_out();
end
endmodule
`default_nettype wire

// ===== tb/power_stage_model.sv
// Power stage stand-in: turns lock conditions into synchronous detect levels.
// Assumes conditions change just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module power_stage_model (
	input wire logic clk, // Core clock
	input wire logic rst_n, // Reset, active low
	input wire logic cur_req, // Overcurrent lock present
	input wire logic stall_req, // Rotor stuck
	input wire logic [2:0] drv_mode, // Driver action from the block
	input wire logic fault_n, // Fault pin from the block
	output logic cur_det, // Current lock detect
	output logic stall_det, // Motor lock detect
	output logic braking // Drivers held off normal control
);
// ****
// Detect flops
// ****
always_ff @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		cur_det <= 1'b0;
		stall_det <= 1'b0;
	end
	else
	begin
		cur_det <= cur_req;
		stall_det <= stall_req;
	end
end
assign braking = drv_mode != 3'h0 && !fault_n;
endmodule
`default_nettype wire
